// ### pof_consts.svh
`ifndef POF_CONSTS_SVH
`define POF_CONSTS_SVH

// Image store geometry: 16 pixels by 8 lines.
`define POF_XMAX 4'hF
`define POF_YMAX 3'h7
`define POF_MEM_AW 7
`define POF_MEM_WORDS 128

// Register byte offsets and decode mask.
`define POF_REG_CTRL 8'h00
`define POF_REG_PAT 8'h04
`define POF_REG_ROI 8'h08
`define POF_REG_STAT 8'h0C
`define POF_ADDR_MASK 8'hFC

// Control and pattern register fields.
`define POF_C_ACQ 0
`define POF_C_FMT 3:1
`define POF_C_ADC 5:4
`define POF_C_SRC 6
`define POF_C_REVX 7
`define POF_C_REVY 8
`define POF_C_PHASE 10:9
`define POF_P_CHOICE 1:0

// Region fields.
`define POF_R_OFFX 3:0
`define POF_R_OFFY 10:8
`define POF_R_WM1 19:16
`define POF_R_HM1 26:24

// Reset values.
`define POF_CTRL_RST 32'h0000_0000
`define POF_ROI_RST 32'h070F_0000

// Bus responses.
`define POF_RESP_OKAY 2'h0
`define POF_RESP_SLVERR 2'h2

// Converter alignment shifts and valid-data masks.
`define POF_SH10 4'h6
`define POF_SH12 4'h4
`define POF_SH14 4'h2
`define POF_MASK10 16'hFFC0
`define POF_MASK12 16'hFFF0
`define POF_MASK14 16'hFFFC

// Colour transform coefficients, scaled by 256.
`define POF_KY_R 18'sh0004D
`define POF_KY_G 18'sh00096
`define POF_KY_B 18'sh0001D
`define POF_KCB_R 18'sh0002B
`define POF_KCB_G 18'sh00055
`define POF_KHALF 18'sh00080
`define POF_KCR_G 18'sh0006B
`define POF_KCR_B 18'sh00015
`define POF_KOFS 18'sh08000
`define POF_KRND 18'sh00080
`define POF_SAT_MAX 10'sh0FF

`endif

// ### pof_formatter.sv
// Function
// - Full format emits luma and both chroma samples for every pixel.
// - Luma and chroma span the whole 0 to 255 range, no footroom.
// - Half format: luma per pixel, chroma pair per two pixels, every line.
// - Quarter format: luma per pixel, chroma pair per four pixels, every line.
// - Narrower output width drops the sample's lowest bits.
// - Wider output width pads the low bits with zeros.
// - Samples sit most significant bit first in a 16-bit word.
// - A 12-bit sample fills bits 15 to 4, mask FFF0.
// - Converter depths 10, 12 and 14 bits are all left-justified.
// - Source select picks which generator the pattern choice addresses.
// - Pipeline generator replaces pixels at the head of processing.
// - Writing off disables only the selected generator.
// - Increment pattern adds one per pixel, wrapping 255 to zero.
// - Frame-varying pattern restarts its sequence when acquisition starts.
// - With both generators on, the pipeline pattern wins.
// - Later processing alters patterns; sensor exposure and gain do not.
// - Real sensor pixels pass only with both generators off.
// - Horizontal mirror reverses pixel order within each line.
// - Vertical mirror reverses line order within each frame.
// - Region offsets apply to the already mirrored image.
// - Horizontal mirror swaps reported phase between red-green and green-red.
// - Vertical mirror swaps reported phase between red-green and green-blue.
// - Luma is 0.299 R plus 0.587 G plus 0.114 B.
// - Chroma uses the standard difference coefficients plus offset 128.
`timescale 1ns/1ps
`default_nettype none
`include "pof_consts.svh"

module pof_formatter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pof_pkg::pof_axi_req_t axi_req,
  output var pof_pkg::pof_axi_rsp_t axi_rsp,
  input wire pof_pkg::pof_pix_in_t pix_in,
  output var pof_pkg::pof_pix_out_t pix_out
);

  pof_pkg::pof_state_t q;
  pof_pkg::pof_state_t d;
  logic [39:0] frame_mem [0:`POF_MEM_WORDS-1];
  logic mem_we;
  logic [`POF_MEM_AW-1:0] mem_waddr;
  logic [39:0] mem_wdata;
  logic [`POF_MEM_AW-1:0] mem_raddr;
  logic [39:0] mem_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] sat8(input logic signed [17:0] v);
    logic signed [9:0] s;
    s = 10'(v >>> 8);
    if (s < 0) begin
      return 8'h00;
    end else if (s > `POF_SAT_MAX) begin
      return 8'hFF;
    end
    return s[7:0];
  endfunction

  function automatic logic [23:0] ycc(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    logic signed [17:0] sr;
    logic signed [17:0] sg;
    logic signed [17:0] sb;
    logic signed [17:0] yy;
    logic signed [17:0] cb;
    logic signed [17:0] cr;
    sr = signed'({10'h000, r});
    sg = signed'({10'h000, g});
    sb = signed'({10'h000, b});
    yy = `POF_KY_R * sr + `POF_KY_G * sg + `POF_KY_B * sb + `POF_KRND;
    cb = `POF_KHALF * sb - `POF_KCB_R * sr - `POF_KCB_G * sg + `POF_KOFS + `POF_KRND;
    cr = `POF_KHALF * sr - `POF_KCR_G * sg - `POF_KCR_B * sb + `POF_KOFS + `POF_KRND;
    // No 16 to 235 scaling is applied, so codes reach both ends of the byte.
    return {sat8(yy), sat8(cb), sat8(cr)};
  endfunction

  logic acq;
  pof_pkg::pof_fmt_t fmt;
  pof_pkg::pof_adc_t adc;
  logic rev_x;
  logic rev_y;
  logic pipe_on;
  logic sens_on;
  logic [1:0] phase_rep;
  assign acq = q.ctrl[`POF_C_ACQ];
  assign fmt = pof_pkg::pof_fmt_t'(q.ctrl[`POF_C_FMT]);
  assign adc = pof_pkg::pof_adc_t'(q.ctrl[`POF_C_ADC]);
  assign rev_x = q.ctrl[`POF_C_REVX];
  assign rev_y = q.ctrl[`POF_C_REVY];
  assign pipe_on = q.pat_pipe != pof_pkg::pof_pat_off;
  assign sens_on = q.pat_sensor != pof_pkg::pof_pat_off;
  assign phase_rep = q.ctrl[`POF_C_PHASE] ^ {rev_y, rev_x};

  // Input side: converter alignment and pattern substitution.
  logic [3:0] cur_x;
  logic [2:0] cur_y;
  logic [7:0] cur_inc;
  logic [3:0] sh;
  logic [15:0] mask;
  logic [15:0] aligned;
  logic [15:0] sens_pat;
  logic [7:0] grey;
  logic [15:0] sel_raw;
  logic [23:0] sel_rgb;
  assign cur_x = pix_in.sof ? 4'h0 : q.in_x;
  assign cur_y = pix_in.sof ? 3'h0 : q.in_y;
  assign cur_inc = pix_in.sof ? 8'h00 : q.inc_val;

  always_comb begin
    unique case (adc)
      pof_pkg::pof_adc_10bit: begin
        sh = `POF_SH10;
        mask = `POF_MASK10;
      end
      pof_pkg::pof_adc_12bit: begin
        sh = `POF_SH12;
        mask = `POF_MASK12;
      end
      default: begin
        sh = `POF_SH14;
        mask = `POF_MASK14;
      end
    endcase
  end

  // Shifting left both discards bits above the depth and zero-fills the low bits.
  assign aligned = 16'({2'h0, pix_in.sample} << sh) & mask;
  assign sens_pat = {4'(cur_x + {1'b0, cur_y}), cur_x, 8'h00} & mask;
  assign grey = (q.pat_pipe == pof_pkg::pof_pat_increment) ? cur_inc
    : 8'({1'b0, cur_y, cur_x} + {q.frame_idx[4:0], 3'h0});

  // Sensor analog controls act outside this block, so they never reach a pattern.
  always_comb begin
    if (pipe_on) begin
      sel_raw = {grey, 8'h00};
      sel_rgb = {grey, grey, grey};
    end else if (sens_on) begin
      sel_raw = sens_pat;
      sel_rgb = {sens_pat[15:8], sens_pat[15:8], sens_pat[15:8]};
    end else begin
      sel_raw = aligned;
      sel_rgb = {pix_in.r, pix_in.g, pix_in.b};
    end
  end

  // Readout side: mirrored coordinates, then the region cut from them.
  logic [3:0] mir_x;
  logic [2:0] mir_y;
  logic [3:0] src_x;
  logic [2:0] src_y;
  logic [23:0] ycc_val;
  assign mir_x = 4'(q.roi[`POF_R_OFFX] + q.out_x);
  assign mir_y = 3'(q.roi[`POF_R_OFFY] + q.out_y);
  assign src_x = rev_x ? 4'(`POF_XMAX - mir_x) : mir_x;
  assign src_y = rev_y ? 3'(`POF_YMAX - mir_y) : mir_y;
  assign mem_raddr = {src_y, src_x};
  assign mem_rdata = frame_mem[mem_raddr];
  assign ycc_val = ycc(mem_rdata[23:16], mem_rdata[15:8], mem_rdata[7:0]);

  always_comb begin
    logic [1:0] choice;
    logic [31:0] rd;
    logic [1:0] rr;
    logic first;
    choice = 2'h0;
    rd = 32'h0000_0000;
    rr = `POF_RESP_OKAY;
    first = 1'b0;
    d = q;
    mem_we = 1'b0;
    mem_waddr = {cur_y, cur_x};
    mem_wdata = {sel_raw, sel_rgb};
    d.acq_prev = acq;
    d.pix.valid = 1'b0;
    d.pix.sof = 1'b0;
    d.pix.sol = 1'b0;
    d.pix.chroma = 1'b0;

    if (acq && !q.acq_prev) begin
      d.frame_idx = 8'h00;
    end

    unique case (q.st)
      pof_pkg::pof_st_capture: begin
        // Input arriving during readout is dropped; one frame store only.
        if (pix_in.valid && acq) begin
          mem_we = 1'b1;
          d.inc_val = 8'(cur_inc + 8'h01);
          if (cur_x == `POF_XMAX) begin
            d.in_x = 4'h0;
            d.in_y = 3'(cur_y + 3'h1);
            if (cur_y == `POF_YMAX) begin
              d.st = pof_pkg::pof_st_readout;
              d.out_x = 4'h0;
              d.out_y = 3'h0;
              d.frame_idx = 8'(q.frame_idx + 8'h01);
            end
          end else begin
            d.in_x = 4'(cur_x + 4'h1);
            d.in_y = cur_y;
          end
        end
      end
      pof_pkg::pof_st_readout: begin
        d.pix.valid = 1'b1;
        d.pix.sol = q.out_x == 4'h0;
        d.pix.sof = (q.out_x == 4'h0) && (q.out_y == 3'h0);
        unique case (fmt)
          pof_pkg::pof_fmt_mosaic_16bit: begin
            d.pix.data = {8'h00, mem_rdata[39:24]};
          end
          pof_pkg::pof_fmt_raw_8bit: begin
            d.pix.data = {16'h0000, mem_rdata[39:32]};
          end
          pof_pkg::pof_fmt_luma_chroma_full_8bit: begin
            d.pix.chroma = 1'b1;
            d.pix.data = ycc_val;
          end
          pof_pkg::pof_fmt_luma_chroma_half_8bit: begin
            first = q.out_x[0] == 1'b0;
            d.pix.chroma = first;
            d.pix.data = first ? ycc_val : {ycc_val[23:16], 16'h0000};
          end
          pof_pkg::pof_fmt_luma_chroma_quarter_8bit: begin
            first = q.out_x[1:0] == 2'h0;
            d.pix.chroma = first;
            d.pix.data = first ? ycc_val : {ycc_val[23:16], 16'h0000};
          end
          default: begin
            d.pix.data = 24'h00_0000;
          end
        endcase
        if (q.out_x == q.roi[`POF_R_WM1]) begin
          d.out_x = 4'h0;
          d.out_y = 3'(q.out_y + 3'h1);
          if (q.out_y == q.roi[`POF_R_HM1]) begin
            d.st = pof_pkg::pof_st_capture;
            d.in_x = 4'h0;
            d.in_y = 3'h0;
          end
        end else begin
          d.out_x = 4'(q.out_x + 4'h1);
        end
      end
    endcase

    // Write address and data are taken independently, in either order.
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (axi_req.awvalid && q.rsp.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.w_held = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.aw_held && q.w_held && !q.rsp.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = `POF_RESP_OKAY;
      unique case (q.awaddr & `POF_ADDR_MASK)
        `POF_REG_CTRL: begin
          // Depth changes mid-frame corrupt alignment; software stops first.
          d.ctrl = merge(q.ctrl, q.wdata, q.wstrb);
        end
        `POF_REG_PAT: begin
          choice = q.wdata[`POF_P_CHOICE];
          if (q.wstrb[0]) begin
            if (q.ctrl[`POF_C_SRC]) begin
              if (pof_pkg::pof_pat_t'(choice) != pof_pkg::pof_pat_sensor) begin
                d.pat_pipe = pof_pkg::pof_pat_t'(choice);
              end
            end else if (choice <= 2'h1) begin
              d.pat_sensor = pof_pkg::pof_pat_t'(choice);
            end
          end
        end
        `POF_REG_ROI: begin
          d.roi = merge(q.roi, q.wdata, q.wstrb);
        end
        `POF_REG_STAT: begin
          d.rsp.bresp = `POF_RESP_OKAY;
        end
        default: begin
          d.rsp.bresp = `POF_RESP_SLVERR;
        end
      endcase
    end

    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      unique case (axi_req.araddr & `POF_ADDR_MASK)
        `POF_REG_CTRL: rd = q.ctrl;
        `POF_REG_PAT: rd = {28'h000_0000, q.pat_pipe, q.pat_sensor};
        `POF_REG_ROI: rd = q.roi;
        `POF_REG_STAT: rd = {20'h0_0000, !pipe_on && !sens_on, q.st == pof_pkg::pof_st_readout,
                             q.frame_idx, phase_rep};
        default: rr = `POF_RESP_SLVERR;
      endcase
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd;
      d.rsp.rresp = rr;
    end

    d.rsp.awready = !d.aw_held;
    d.rsp.wready = !d.w_held;
    d.rsp.arready = !d.rsp.rvalid;

    if (!aresetn) begin
      d = '0;
      d.ctrl = `POF_CTRL_RST;
      d.roi = `POF_ROI_RST;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      frame_mem[mem_waddr] <= mem_wdata;
    end
  end

  assign axi_rsp = q.rsp;
  assign pix_out = q.pix;

endmodule // pof_formatter

`default_nettype wire

// ### pof_formatter_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pof_consts.svh"
module pof_formatter_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pof_pkg::pof_axi_req_t axi_req,
  input wire pof_pkg::pof_axi_rsp_t axi_rsp,
  input wire pof_pkg::pof_pix_in_t pix_in,
  input wire pof_pkg::pof_pix_out_t pix_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Format snooping assumes address and data are taken on one edge.
  logic [2:0] fmt_q;
  logic [1:0] adc_q;
  logic [15:0] msk;
  logic pv;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_q <= 3'h0;
      adc_q <= 2'h0;
    end else if (axi_req.wvalid && axi_rsp.wready && axi_req.awaddr == `POF_REG_CTRL) begin
      fmt_q <= axi_req.wdata[`POF_C_FMT];
      adc_q <= axi_req.wdata[`POF_C_ADC];
    end
  end
  assign msk = adc_q == 2'h0 ? `POF_MASK10 : adc_q == 2'h1 ? `POF_MASK12 : `POF_MASK14;
  assign pv = pix_out.valid;
  sequence bare_run3;
    (!(pv && pix_out.chroma) || pix_out.sol) [*3];
  endsequence
  full_chroma_a: assert property (pv && fmt_q == 3'h2 |-> pix_out.chroma)
    else $error("full format pixel without chroma");
  half_chroma_a: assert property (pv && pix_out.chroma && fmt_q == 3'h3 |=> !(pv && pix_out.chroma) || pix_out.sol)
    else $error("half format chroma too dense");
  quarter_chroma_a: assert property (pv && pix_out.chroma && fmt_q == 3'h4 |=> bare_run3)
    else $error("quarter format chroma too dense");
  line_chroma_a: assert property (pv && pix_out.sol && fmt_q inside {3'h3, 3'h4} |-> pix_out.chroma)
    else $error("line start without chroma");
  align_pad_a: assert property (pv && fmt_q == 3'h0 |-> (pix_out.data[15:0] & ~msk) == 16'h0000)
    else $error("padding bits not clear");
  frame_start_a: assert property ($rose(pv) |-> pix_out.sof && pix_out.sol)
    else $error("readout began without frame start");
  rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
    else $error("read answer late");
  rd_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while answer pending");
  wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##[1:3] axi_rsp.bvalid)
    else $error("write answer late");
endmodule // pof_formatter_checker
bind pof_formatter pof_formatter_checker chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .pix_in(pix_in),
  .pix_out(pix_out)
);
`default_nettype wire

// ### pof_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pof_consts.svh"
module pof_formatter_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  pof_pkg::pof_axi_req_t rq = '0;
  pof_pkg::pof_axi_rsp_t rs;
  pof_pkg::pof_pix_in_t px = '0;
  pof_pkg::pof_pix_out_t po;
  int bad_count = 0;
  int checks = 0;
  int dep = 10;
  int offx = 0;
  int offy = 0;
  int w = 16;
  int h = 8;
  int mx = 0;
  int my = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  always #50 aclk = ~aclk;
  pof_formatter dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs), .pix_in(px), .pix_out(po));
  pof_host host (.aclk(aclk), .aresetn(aresetn), .pix_out(po));
  task automatic conclude;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
      if (rs.bvalid) break;
    end
    rq.bready <= 1'b0;
    if (i >= 50) hang();
  endtask
  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (rs.arready) rq.arvalid <= 1'b0;
      if (rs.rvalid) break;
    end
    rd = rs.rdata;
    rr = rs.rresp;
    rq.rready <= 1'b0;
    if (i >= 50) hang();
  endtask
  task automatic frame;
    int i;
    int f0;
    f0 = host.nf;
    for (i = 0; i < 128; i++) begin
      @(posedge aclk);
      px.valid <= 1'b1;
      px.sof <= i == 0;
      px.sample <= {i[1:0], 1'b0, i[6:4], i[3:0], 4'hA};
      px.r <= {i[3:0], i[3:0]};
      px.g <= {i[6:4], 5'h1F};
      px.b <= ~{i[3:0], i[3:0]};
    end
    @(posedge aclk);
    px.valid <= 1'b0;
    px.sof <= 1'b0;
    for (i = 0; i < 400 && (host.nf == f0 || po.valid); i++) @(posedge aclk);
    if (i >= 400) hang();
  endtask
  function automatic int sat(input int v);
    return v > 255 ? 255 : v;
  endfunction
  function automatic logic [24:0] ev(input int k, input int p, input int x, input int y, input int fi,
    input int ox);
    logic [15:0] a;
    logic [7:0] r, g, b;
    int s, yv, cb, cr;
    logic c;
    s = {x[1:0], 1'b0, y[2:0], x[3:0], 4'hA};
    a = 16'((s % (1 << dep)) << (16 - dep));
    r = {x[3:0], x[3:0]};
    g = {y[2:0], 5'h1F};
    b = ~r;
    if (p == 1) begin
      a = {4'(x + y), x[3:0], 8'h00} & (16'hFFFF << (16 - dep));
      r = a[15:8];
      g = r;
      b = r;
    end
    if (p > 1) begin
      r = 8'({y[2:0], x[3:0]} + fi * 8);
      g = r;
      b = r;
      a = {r, 8'h00};
    end
    if (k == 0) return {9'h000, a};
    if (k == 1) return {17'h00000, a[15:8]};
    yv = sat((77 * r + 150 * g + 29 * b + 128) >> 8);
    cb = sat((128 * b - 43 * r - 85 * g + 32896) >> 8);
    cr = sat((128 * r - 107 * g - 21 * b + 32896) >> 8);
    c = k == 2 || (k == 3 && ox % 2 == 0) || (k == 4 && ox % 4 == 0);
    return {c, 8'(yv), c ? {8'(cb), 8'(cr)} : 16'h0000};
  endfunction
  task automatic verify(input int k, input int p, input int fi);
    int j, x, y;
    logic [24:0] m;
    m = k == 0 ? 25'h100FFFF : k == 1 ? 25'h10000FF : 25'h1FFFFFF;
    chk(host.n, w * h);
    for (j = 0; j < w * h; j++) begin
      x = (offx + j % w) % 16;
      y = (offy + j / w) % 8;
      if (mx) x = 15 - x;
      if (my) y = 7 - y;
      chk({host.mem[j].chroma, host.mem[j].data} & m, ev(k, p, x, y, fi, j % w));
      chk(host.mem[j].sol, j % w == 0);
    end
  endtask
  initial begin
    int k, d, m;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`POF_REG_CTRL);
    chk(rd, `POF_CTRL_RST);
    rdr(`POF_REG_ROI);
    chk(rd, `POF_ROI_RST);
    rdr(`POF_REG_PAT);
    chk(rd, 32'h0000_0000);
    rdr(8'h10);
    chk(rr, `POF_RESP_SLVERR);
    rdr(`POF_REG_STAT);
    chk(rd[11], 1'b1);
    for (k = 0; k < 5; k++) begin
      for (d = 0; d < 3; d++) begin
        // Acquisition is stopped by the same write that moves the converter depth.
        wr(`POF_REG_CTRL, d << 4);
        wr(`POF_REG_CTRL, (d << 4) | (k << 1) | 1);
        dep = 10 + 2 * d;
        frame();
        verify(k, 0, 0);
      end
    end
    // No exposure or gain loop lives here, so none needs switching off.
    wr(`POF_REG_CTRL, 32'h0000_0065);
    wr(`POF_REG_PAT, 32'h0000_0002);
    frame();
    verify(2, 2, 0);
    wr(`POF_REG_CTRL, 32'h0000_0025);
    wr(`POF_REG_PAT, 32'h0000_0001);
    rdr(`POF_REG_PAT);
    chk(rd[3:0], 4'h9);
    rdr(`POF_REG_STAT);
    chk(rd[11], 1'b0);
    frame();
    verify(2, 2, 0);
    wr(`POF_REG_CTRL, 32'h0000_0065);
    wr(`POF_REG_PAT, 32'h0000_0000);
    rdr(`POF_REG_PAT);
    chk(rd[3:0], 4'h1);
    wr(`POF_REG_CTRL, 32'h0000_0023);
    frame();
    verify(1, 1, 0);
    wr(`POF_REG_CTRL, 32'h0000_0062);
    wr(`POF_REG_PAT, 32'h0000_0003);
    wr(`POF_REG_CTRL, 32'h0000_0063);
    rdr(`POF_REG_STAT);
    chk(rd[9:2], 8'h00);
    frame();
    verify(1, 3, 0);
    frame();
    verify(1, 3, 1);
    wr(`POF_REG_CTRL, 32'h0000_0062);
    wr(`POF_REG_CTRL, 32'h0000_0063);
    frame();
    verify(1, 3, 0);
    wr(`POF_REG_PAT, 32'h0000_0000);
    // The sensor generator is still on from the earlier scenario, so switch it off for real data.
    wr(`POF_REG_CTRL, 32'h0000_0022);
    wr(`POF_REG_PAT, 32'h0000_0000);
    rdr(`POF_REG_STAT);
    chk(rd[11], 1'b1);
    // The region runs past the right edge so the wrap is exercised too.
    wr(`POF_REG_ROI, 32'h0203_050E);
    offx = 14;
    offy = 5;
    w = 4;
    h = 3;
    for (m = 0; m < 4; m++) begin
      mx = m % 2;
      my = m / 2;
      wr(`POF_REG_CTRL, 32'h0000_0223 | (m << 7));
      rdr(`POF_REG_STAT);
      chk(rd[1:0], m[1:0] ^ 2'h1);
      frame();
      verify(1, 0, 0);
    end
    conclude();
  end
endmodule // pof_formatter_tb
`default_nettype wire

// ### pof_host.sv
`timescale 1ns/1ps
`default_nettype none
module pof_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pof_pkg::pof_pix_out_t pix_out
);
  // The host link sink never stalls, so it keeps every pixel it sees.
  pof_pkg::pof_pix_out_t mem [0:127];
  int n;
  int nf;
  always @(posedge aclk) begin
    if (!aresetn) begin
      n <= 0;
      nf <= 0;
    end else if (pix_out.valid) begin
      mem[pix_out.sof ? 7'h00 : n[6:0]] <= pix_out;
      n <= pix_out.sof ? 1 : n + 1;
      nf <= nf + pix_out.sof;
    end
  end
endmodule // pof_host
`default_nettype wire

// ### pof_pkg.sv
`default_nettype none
package pof_pkg;

  typedef enum logic [2:0] {
    pof_fmt_mosaic_16bit,
    pof_fmt_raw_8bit,
    pof_fmt_luma_chroma_full_8bit,
    pof_fmt_luma_chroma_half_8bit,
    pof_fmt_luma_chroma_quarter_8bit
  } pof_fmt_t;

  typedef enum logic [1:0] {
    pof_pat_off,
    pof_pat_sensor,
    pof_pat_increment,
    pof_pat_variable
  } pof_pat_t;

  typedef enum logic [1:0] {
    pof_adc_10bit,
    pof_adc_12bit,
    pof_adc_14bit
  } pof_adc_t;

  typedef enum logic [1:0] {
    pof_mosaic_red_green_16bit,
    pof_mosaic_green_red_16bit,
    pof_mosaic_green_blue_16bit,
    pof_mosaic_blue_green_16bit
  } pof_phase_t;

  typedef enum logic {
    pof_st_capture,
    pof_st_readout
  } pof_st_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pof_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pof_axi_rsp_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [13:0] sample;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pof_pix_in_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic chroma;
    logic [23:0] data;
  } pof_pix_out_t;

  typedef struct packed {
    pof_st_t st;
    logic [31:0] ctrl;
    logic [31:0] roi;
    pof_pat_t pat_sensor;
    pof_pat_t pat_pipe;
    logic acq_prev;
    logic [7:0] frame_idx;
    logic [7:0] inc_val;
    logic [3:0] in_x;
    logic [2:0] in_y;
    logic [3:0] out_x;
    logic [2:0] out_y;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    pof_axi_rsp_t rsp;
    pof_pix_out_t pix;
  } pof_state_t;

endpackage

`default_nettype wire
